// *** inc/bcs_pkg.sv ***
package bcs_pkg;

    // clock rate
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

    // debounce filter in ms
    localparam int unsigned DEB_MIN_MS       = 10;
    localparam int unsigned DEB_MAX_MS       = 150;
    localparam int unsigned DEB_DEF_MS       = 50;

    // long press threshold in ms
    localparam int unsigned LONG_MIN_MS      = 200;
    localparam int unsigned LONG_MAX_MS      = 65535;
    localparam int unsigned LONG_DEF_MS      = 500;

    // inter-command delay in ms
    localparam int unsigned GAP_MAX_MS       = 20000;
    localparam int unsigned GAP_DEF_MS       = 0;

    // sequence length and widths
    localparam int unsigned NCMD             = 4;
    localparam int unsigned MS_W             = 16;
    localparam int unsigned TICK_W           = 16;

    // register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_TIME        = 8'h04;
    localparam logic [7:0]  ADDR_GAP         = 8'h08;
    localparam logic [7:0]  ADDR_CMD0        = 8'h10;
    localparam logic [7:0]  ADDR_STAT        = 8'h20;
    localparam logic [7:0]  ADDR_TX          = 8'h24;

    // ctrl field positions
    localparam int unsigned CTRL_FUNC        = 0;
    localparam int unsigned CTRL_NC          = 1;
    localparam int unsigned CTRL_LONGEN      = 2;
    localparam int unsigned CTRL_SINGLE      = 3;
    localparam int unsigned CTRL_AMT_LO      = 4;
    localparam int unsigned CTRL_USE_LO      = 8;
    localparam logic [31:0] CTRL_RST         = 32'h0000_0F32;

    // data type codes
    typedef enum logic [1:0] {
        BCS_DT_BIT  = 2'b00,
        BCS_DT_U8   = 2'b01,
        BCS_DT_PCT  = 2'b10,
        BCS_DT_HVAC = 2'b11
    } bcs_dtype_t;

    // one command entry
    typedef struct packed {
        bcs_dtype_t dtype;
        logic [7:0] val_short;
        logic [7:0] val_long;
    } bcs_cmd_t;

    // outgoing telegram
    typedef struct packed {
        logic [1:0] obj;
        bcs_dtype_t dtype;
        logic [7:0] value;
        logic       is_long;
    } bcs_tx_t;

    localparam bcs_cmd_t CMD_RST             = '{BCS_DT_BIT, 8'h01, 8'h00};
endpackage

// *** logic/bcs_debounce.sv ***
`timescale 1ns/100ps
module bcs_debounce
    import bcs_pkg::*;
(
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    // millisecond tick and filter time
    input  wire logic             ms_tick_in,
    input  wire logic [MS_W-1:0]  filt_ms_in,
    // raw and filtered level
    input  wire logic             raw_in,
    output logic                  clean_out
);
    logic            sync_a_q, sync_a_d;   // first stage, read only by second
    logic            sync_b_q, sync_b_d;
    logic            clean_q, clean_d;
    logic [MS_W-1:0] cnt_q, cnt_d;         // ms the new level has held

    // filter: level must hold filt_ms before acceptance
    always_comb begin
        sync_a_d = raw_in;
        sync_b_d = sync_a_q;
        clean_d  = clean_q;
        cnt_d    = cnt_q;
        if (sync_b_q == clean_q) begin
            cnt_d = '0;
        end else if (ms_tick_in) begin
            if (cnt_q + 16'h0001 >= filt_ms_in) begin
                clean_d = sync_b_q;
                cnt_d   = '0;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sync_a_q <= 1'b0;
            sync_b_q <= 1'b0;
            clean_q  <= 1'b0;
            cnt_q    <= '0;
        end else begin
            sync_a_q <= sync_a_d;
            sync_b_q <= sync_b_d;
            clean_q  <= clean_d;
            cnt_q    <= cnt_d;
        end
    end

    assign clean_out = clean_q;

    chk_deb_no_glitch: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (clean_q != $past(clean_q)) |-> $past(sync_b_q) == clean_q)
        else $error("filtered level changed to a level not seen");
endmodule

// *** logic/bcs_seq.sv ***
`timescale 1ns/100ps
// Operation
// - up to four commands per input
// - each press advances, wraps to first
// - function none ignores the input
// - contact type sets pressed level
// - classify short/long before any command
// - long only after configured hold threshold
// - configurable delay between sequence commands
// - single shared or separate output objects
// - separate mode skips disabled objects
// - data type formats transmitted value
// - short and long value per command
// - debounce 10 to 150 ms filter
module bcs_seq
    import bcs_pkg::*;
#(parameter int unsigned CYC_MS = CYC_PER_MS)  // cycles per ms tick, shortened only in simulation
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    // contact input
    input  wire logic        contact_in,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // telegram output
    output logic             tx_valid_out,
    output bcs_tx_t          tx_out
);
    typedef enum logic [1:0] {
        BCS_ST_IDLE  = 2'b00,
        BCS_ST_HELD  = 2'b01,
        BCS_ST_GAP   = 2'b10
    } bcs_state_t;

    // next enabled position after p (wraps)
    function automatic logic [1:0] next_pos(input logic [1:0] p, input logic [3:0] en);
        logic [1:0] r;
        r = p;
        for (int i = NCMD; i >= 1; i--) begin
            if (en[2'(p + 2'(i))]) begin
                r = 2'(p + 2'(i));
            end
        end
        return r;
    endfunction

    // configuration registers
    logic [31:0]    ctrl_q, ctrl_d;
    logic [MS_W-1:0] long_ms_q, long_ms_d;
    logic [MS_W-1:0] deb_ms_q, deb_ms_d;
    logic [MS_W-1:0] gap_ms_q, gap_ms_d;
    bcs_cmd_t       cmd_q [NCMD];
    bcs_cmd_t       cmd_d [NCMD];
    // ahb address phase capture
    logic           wr_q, wr_d;
    logic           rd_q, rd_d;
    logic [7:0]     adr_q, adr_d;
    logic [31:0]    rdat_q, rdat_d;
    // sequencer state
    bcs_state_t     st_q, st_d;
    logic [1:0]     pos_q, pos_d;
    logic [MS_W-1:0] hold_q, hold_d;       // ms pressed / ms waited
    logic           pend_q, pend_d;        // press waiting for gap end
    logic           prs_q, prs_d;          // pressed last cycle; 1 at reset so a stale level is no press
    logic           plong_q, plong_d;
    logic           txv_q, txv_d;
    bcs_tx_t        tx_q, tx_d;
    logic [7:0]     ntx_q, ntx_d;          // telegram count for status
    // ms timebase
    logic [TICK_W-1:0] tick_q, tick_d;
    logic           ms_tick;
    logic           clean, pressed, func_on, longen, single;
    logic [1:0]     amt;
    logic [3:0]     en_mask;
    logic           evt, evt_long;
    logic [7:0]     fmt;

    // shared ms tick, not a clock enable, just a pulse
    assign ms_tick = (tick_q == TICK_W'(CYC_MS - 1));
    assign tick_d  = ms_tick ? '0 : tick_q + 16'h0001;

    bcs_debounce u_bcs_debounce (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .ms_tick_in (ms_tick),
        .filt_ms_in (deb_ms_q),
        .raw_in     (contact_in),
        .clean_out  (clean)
    );

    // polarity: nc contact is pressed when open (low)
    assign pressed = ctrl_q[CTRL_NC] ? ~clean : clean;
    assign func_on = ctrl_q[CTRL_FUNC];
    assign longen  = ctrl_q[CTRL_LONGEN];
    assign single  = ctrl_q[CTRL_SINGLE];
    assign amt     = ctrl_q[CTRL_AMT_LO +: 2];
    // enabled set: single uses amount, separate uses flags
    // amount code 0 or 1 gives two values, up to four
    always_comb begin
        en_mask = 4'h0;
        if (single) begin
            for (int i = 0; i < NCMD; i++) begin
                en_mask[i] = (2'(i) <= amt) || (i < 2);
            end
        end else begin
            en_mask = ctrl_q[CTRL_USE_LO +: NCMD];
        end
    end

    // bus: address phase capture and register writes
    always_comb begin
        ctrl_d    = ctrl_q;
        long_ms_d = long_ms_q;
        deb_ms_d  = deb_ms_q;
        gap_ms_d  = gap_ms_q;
        cmd_d     = cmd_q;
        wr_d      = hsel && hready && htrans[1] && hwrite;
        rd_d      = hsel && hready && htrans[1] && !hwrite;
        adr_d     = (hsel && hready) ? haddr[7:0] : adr_q;
        rdat_d    = rdat_q;
        if (wr_q) begin
            case (adr_q)
                ADDR_CTRL: ctrl_d = hwdata;
                ADDR_TIME: begin
                    long_ms_d = (hwdata[15:0] < 16'(LONG_MIN_MS)) ? 16'(LONG_MIN_MS) : hwdata[15:0];
                    if (hwdata[31:16] < 16'(DEB_MIN_MS)) begin
                        deb_ms_d = 16'(DEB_MIN_MS);
                    end else if (hwdata[31:16] > 16'(DEB_MAX_MS)) begin
                        deb_ms_d = 16'(DEB_MAX_MS);
                    end else begin
                        deb_ms_d = hwdata[31:16];
                    end
                end
                ADDR_GAP: gap_ms_d = (hwdata[15:0] > 16'(GAP_MAX_MS)) ? 16'(GAP_MAX_MS) : hwdata[15:0];
                default: begin
                    for (int i = 0; i < NCMD; i++) begin
                        if (adr_q == 8'(ADDR_CMD0 + 4 * i)) begin
                            cmd_d[i] = bcs_cmd_t'(hwdata[17:0]);
                        end
                    end
                end
            endcase
        end
        // read data for next-phase answer
        if (rd_d) begin
            case (haddr[7:0])
                ADDR_CTRL: rdat_d = ctrl_q;
                ADDR_TIME: rdat_d = {deb_ms_q, long_ms_q};
                ADDR_GAP:  rdat_d = {16'h0000, gap_ms_q};
                ADDR_STAT: rdat_d = {16'h0000, ntx_q, 3'h0, pend_q, st_q, pos_q};
                ADDR_TX:   rdat_d = {19'h00000, tx_q};
                default: begin
                    rdat_d = 32'h0000_0000;
                    for (int i = 0; i < NCMD; i++) begin
                        if (haddr[7:0] == 8'(ADDR_CMD0 + 4 * i)) begin
                            rdat_d = {14'h0000, cmd_q[i]};
                        end
                    end
                end
            endcase
        end
    end

    assign hrdata    = rdat_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        logic [7:0] v;
        v = (plong_q && longen) ? cmd_q[pos_q].val_long : cmd_q[pos_q].val_short;
        case (cmd_q[pos_q].dtype)
            BCS_DT_BIT:  fmt = {7'h00, v[0]};
            BCS_DT_PCT:  fmt = (v > 8'h64) ? 8'hFF : 8'((16'(v) * 16'h00FF + 16'h0032) / 16'h0064);
            BCS_DT_HVAC: fmt = (v > 8'h04) ? 8'h00 : v;
            default:     fmt = v;
        endcase
    end

    // sequencer: press classify, send, gap
    always_comb begin
        st_d     = st_q;
        pos_d    = pos_q;
        hold_d   = hold_q;
        pend_d   = pend_q;
        plong_d  = plong_q;
        txv_d    = 1'b0;
        tx_d     = tx_q;
        ntx_d    = ntx_q;
        prs_d    = pressed;
        evt      = 1'b0;
        evt_long = 1'b0;
        case (st_q)
            BCS_ST_IDLE: begin
                hold_d = '0;
                if (func_on && pressed && !prs_q) begin
                    st_d = BCS_ST_HELD;
                end
            end
            BCS_ST_HELD: begin
                if (ms_tick && hold_q != 16'hFFFF) begin
                    hold_d = hold_q + 16'h0001;
                end
                // classify on release when enabled, else at press
                if (!longen) begin
                    evt  = 1'b1;
                end else if (!pressed) begin
                    evt = 1'b1;
                    // long only at or past threshold
                    evt_long = (hold_q >= long_ms_q);
                end
                if (!func_on) begin
                    st_d = BCS_ST_IDLE;
                end else if (evt) begin
                    st_d    = BCS_ST_GAP;
                    pend_d  = 1'b1;
                    plong_d = evt_long;
                    hold_d  = '0;
                end
            end
            BCS_ST_GAP: begin
                // send after gap, gap counts from classification of this press
                if (func_on && pend_q && hold_q >= gap_ms_q) begin
                    txv_d  = 1'b1;
                    tx_d   = '{single ? 2'b00 : pos_q, cmd_q[pos_q].dtype, fmt, plong_q};
                    ntx_d  = ntx_q + 8'h01;
                    pend_d = 1'b0;
                    pos_d  = next_pos(pos_q, en_mask);
                end
                if (ms_tick && hold_q != 16'hFFFF) begin
                    hold_d = hold_q + 16'h0001;
                end
                // wait for release and gap before next press
                if (!pend_q && !(longen ? 1'b0 : pressed) && hold_q >= gap_ms_q) begin
                    st_d = BCS_ST_IDLE;
                end
                if (!func_on) begin
                    st_d   = BCS_ST_IDLE;
                    pend_d = 1'b0;
                end
            end
            default: st_d = BCS_ST_IDLE;
        endcase
        // keep position on an enabled command
        if (en_mask != 4'h0 && !en_mask[pos_d]) begin
            pos_d = next_pos(pos_d, en_mask);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            ctrl_q    <= CTRL_RST;
            long_ms_q <= 16'(LONG_DEF_MS);
            deb_ms_q  <= 16'(DEB_DEF_MS);
            gap_ms_q  <= 16'(GAP_DEF_MS);
            for (int i = 0; i < NCMD; i++) begin
                cmd_q[i] <= CMD_RST;
            end
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            adr_q     <= 8'h00;
            rdat_q    <= 32'h0000_0000;
            tick_q    <= '0;
            st_q      <= BCS_ST_IDLE;
            // reset to first command (all enabled by default)
            pos_q     <= 2'b00;
            hold_q    <= '0;
            pend_q    <= 1'b0;
            prs_q     <= 1'b1;
            plong_q   <= 1'b0;
            txv_q     <= 1'b0;
            tx_q      <= '0;
            ntx_q     <= 8'h00;
        end else begin
            ctrl_q    <= ctrl_d;
            long_ms_q <= long_ms_d;
            deb_ms_q  <= deb_ms_d;
            gap_ms_q  <= gap_ms_d;
            cmd_q     <= cmd_d;
            wr_q      <= wr_d;
            rd_q      <= rd_d;
            adr_q     <= adr_d;
            rdat_q    <= rdat_d;
            tick_q    <= tick_d;
            st_q      <= st_d;
            pos_q     <= pos_d;
            hold_q    <= hold_d;
            pend_q    <= pend_d;
            prs_q     <= prs_d;
            plong_q   <= plong_d;
            txv_q     <= txv_d;
            tx_q      <= tx_d;
            ntx_q     <= ntx_d;
        end
    end

    assign tx_valid_out = txv_q;
    assign tx_out       = tx_q;

    chk_func_off_quiet: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !$past(func_on) |-> !txv_q)
        else $error("telegram sent while function off");
    chk_pos_advance: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_d && $countones(en_mask) > 1) |=> pos_q != $past(pos_q))
        else $error("position did not advance");
    chk_obj_enabled: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_d && !single && en_mask != 4'h0) |-> en_mask[pos_q])
        else $error("disabled object sent");
    chk_single_obj: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_q && $past(single)) |-> tx_q.obj == 2'b00)
        else $error("single mode used other object");
    chk_no_early: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (st_q == BCS_ST_HELD) |=> !txv_q)
        else $error("sent before classification");
    chk_long_thresh: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (evt_long && st_q == BCS_ST_HELD) |-> hold_q >= long_ms_q && longen)
        else $error("long without threshold");
    chk_gap_wait: assert property (@(posedge clock_in) disable iff (!resetn_in)
        txv_d |-> hold_q >= gap_ms_q)
        else $error("gap not respected");
    chk_bit_fmt: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_q && tx_q.dtype == BCS_DT_BIT) |-> tx_q.value[7:1] == 7'h00)
        else $error("bit value wider than one bit");
    chk_deb_range: assert property (@(posedge clock_in) disable iff (!resetn_in)
        deb_ms_q >= 16'(DEB_MIN_MS) && deb_ms_q <= 16'(DEB_MAX_MS))
        else $error("filter time out of range");
    // first send after reset is command zero when command zero is enabled
    chk_first_cmd: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_d && ntx_q == 8'h00 && !single && en_mask[0]) |-> pos_q == 2'b00)
        else $error("first send not first command");
    // long value chosen on long press
    chk_long_value: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (txv_d && plong_q && longen && cmd_q[pos_q].dtype == BCS_DT_U8) |=> tx_q.value == $past(cmd_q[pos_q].val_long))
        else $error("long value not used");
    chk_amount: assert property (@(posedge clock_in) disable iff (!resetn_in)
        single |-> $countones(en_mask) >= 2)
        else $error("single mode under two values");
endmodule

// *** verif/bcs_contact_model.sv ***
`timescale 1ns/100ps
// bouncing pushbutton contact seen from the digital input
module bcs_contact_model
    import bcs_pkg::*;
#(
    parameter int BOUNCE_N   = 5,
    parameter int BOUNCE_CYC = 2000
)
(
    // clock
    input  wire logic clock_in,
    // operator action and wiring
    input  wire logic press_in,
    input  wire logic nc_in,
    // raw level on the input
    output logic      contact_out
);
    logic last_q   = 1'b0;   // settled operator state
    int   bounce_q = 0;      // bounces still to come
    int   cnt_q    = 0;      // cycles within one bounce

    // every change of the operator state chatters before it settles
    always_ff @(posedge clock_in) begin
        if (press_in !== last_q) begin
            last_q   <= press_in;
            bounce_q <= BOUNCE_N;
            cnt_q    <= 0;
        end else if (bounce_q > 0) begin
            cnt_q <= (cnt_q == BOUNCE_CYC - 1) ? 0 : cnt_q + 1;
            if (cnt_q == BOUNCE_CYC - 1) begin
                bounce_q <= bounce_q - 1;
            end
        end
    end

    // closed contact reads high, so a break contact inverts it
    assign contact_out = (last_q ^ nc_in) ^ (bounce_q > 0 && bounce_q[0]);
endmodule

// *** verif/button_command_sequencer_bench.sv ***
`timescale 1ns/100ps
module button_command_sequencer_bench
    import bcs_pkg::*;
;
    localparam int unsigned BENCH_MS = 50;  // cycles per ms tick, keeps the run short
    logic        clock_in  = 1'b0;  // system clock
    logic        resetn_in = 1'b0;  // sync reset, low active
    logic        contact;           // raw contact level
    logic        press     = 1'b0;  // operator holds the button
    logic        nc        = 1'b1;  // break contact wiring
    logic        hsel      = 1'b1;  // single slave always selected
    logic [31:0] haddr     = 32'h0000_0000;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [2:0]  hsize     = 3'h2;
    logic [31:0] hwdata    = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        tx_valid;
    bcs_tx_t     tx;
    bcs_tx_t     txq[$];            // telegrams seen
    int          miscompares = 0;
    int          tests_run   = 0;

    // clock, 20 ns period
    initial begin
        forever #10 clock_in = ~clock_in;
    end

    bcs_seq #(.CYC_MS(BENCH_MS)) u_bcs_seq (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .contact_in  (contact),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata      (hrdata),
        .hreadyout   (hready),
        .hresp       (hresp),
        .tx_valid_out(tx_valid),
        .tx_out      (tx)
    );

    bcs_contact_model #(.BOUNCE_N(5), .BOUNCE_CYC(20)) u_bcs_contact_model (
        .clock_in   (clock_in),
        .press_in   (press),
        .nc_in      (nc),
        .contact_out(contact)
    );

    // collect every issued telegram
    always @(posedge clock_in) begin
        if (tx_valid === 1'b1) begin
            txq.push_back(tx);
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_ms(input int n);
        repeat (n * BENCH_MS) @(posedge clock_in);
    endtask

    // one single word transfer, address phase then data phase
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(a, 1'b1, d, dummy);
    endtask

    // fresh reset, then the whole configuration
    task automatic cfg(input logic [31:0] ctrl, input logic [31:0] gap, input logic [31:0] c[4]);
        resetn_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        resetn_in <= 1'b1;
        nc        <= ctrl[CTRL_NC];
        @(posedge clock_in);
        wr(ADDR_TIME, {16'h000A, 16'h00C8});
        wr(ADDR_GAP, gap);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CMD0 + 8'(4 * i), c[i]);
        end
        wr(ADDR_CTRL, ctrl);
        wait_ms(15);
    endtask

    // press, hold, release; nothing may go out while held when late
    task automatic push(input int hold_ms, input bit late);
        txq.delete();
        press <= 1'b1;
        wait_ms(hold_ms);
        if (late) begin
            check(32'(txq.size()), 32'h0000_0000);
        end
        press <= 1'b0;
        wait_ms(15);
    endtask

    // exactly one telegram of the given content
    task automatic expect_tx(input logic [1:0] o, input bcs_dtype_t d, input logic [7:0] v, input logic l);
        bcs_tx_t e;
        e = '{o, d, v, l};
        check(32'(txq.size()), 32'h0000_0001);
        if (txq.size() > 0) begin
            check(32'(txq[0]), 32'(e));
        end
    endtask

    // function none after reset: presses are ignored
    task automatic t_none();
        logic [31:0] rd;
        ahb(ADDR_CTRL, 1'b0, 32'h0, rd);
        check(rd, CTRL_RST);
        ahb(8'h40, 1'b0, 32'h0, rd);
        check(rd, 32'h0000_0000);
        ahb(ADDR_STAT, 1'b0, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h0000_0000);
        push(20, 1'b0);
        check(32'(txq.size()), 32'h0000_0000);
    endtask

    // separate objects, only B and D enabled
    task automatic t_separate();
        logic [31:0] c[4];
        c = '{32'h0001_1200, 32'h0002_6400, 32'h0000_0100, 32'h0003_0700};
        cfg(32'h0000_0A01, 32'h0, c);
        push(20, 1'b0);
        expect_tx(2'h1, BCS_DT_PCT, 8'hFF, 1'b0);
        push(20, 1'b0);
        expect_tx(2'h3, BCS_DT_HVAC, 8'h00, 1'b0);
        push(20, 1'b0);
        expect_tx(2'h1, BCS_DT_PCT, 8'hFF, 1'b0);
    endtask

    // single object, three values, short and long
    task automatic t_single();
        logic [31:0] c[4];
        c = '{32'h0001_2131, 32'h0001_2232, 32'h0001_2333, 32'h0001_2434};
        cfg(32'h0000_0F2D, 32'h0, c);
        push(20, 1'b1);
        expect_tx(2'h0, BCS_DT_U8, 8'h21, 1'b0);
        push(230, 1'b1);
        expect_tx(2'h0, BCS_DT_U8, 8'h32, 1'b1);
        push(20, 1'b1);
        expect_tx(2'h0, BCS_DT_U8, 8'h23, 1'b0);
        push(20, 1'b1);
        expect_tx(2'h0, BCS_DT_U8, 8'h21, 1'b0);
    endtask

    // break contact and a 5 ms gap before sending
    task automatic t_gap();
        logic [31:0] c[4];
        c = '{32'h0001_1200, 32'h0001_1300, 32'h0001_1400, 32'h0001_1500};
        cfg(32'h0000_0103, 32'h0000_0005, c);
        txq.delete();
        press <= 1'b1;
        wait_ms(13);
        check(32'(txq.size()), 32'h0000_0000);
        wait_ms(7);
        expect_tx(2'h0, BCS_DT_U8, 8'h12, 1'b0);
        press <= 1'b0;
        wait_ms(15);
    endtask

    // single object, amount code 0 still gives two values
    task automatic t_amount();
        logic [31:0] c[4];
        c = '{32'h0000_0100, 32'h0001_4400, 32'h0001_5500, 32'h0001_6600};
        cfg(32'h0000_0009, 32'h0, c);
        push(20, 1'b0);
        expect_tx(2'h0, BCS_DT_BIT, 8'h01, 1'b0);
        push(20, 1'b0);
        expect_tx(2'h0, BCS_DT_U8, 8'h44, 1'b0);
        push(20, 1'b0);
        expect_tx(2'h0, BCS_DT_BIT, 8'h01, 1'b0);
    endtask

    // watchdog; the expected run is about 35000 cycles
    initial begin
        repeat (80_000) @(posedge clock_in);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        t_none();
        t_separate();
        t_single();
        t_gap();
        t_amount();
        report_and_stop();
    end
endmodule
